// ---- hw/dacc_pkg.sv ----
// package: register map, field positions and bus-cycle types of the dram access sequencer
package dacc_pkg;
    // register word offsets (byte addresses)
    localparam logic [7:0] CTRL_A_OFS = 8'h00; // dram_control_a
    localparam logic [7:0] CTRL_B_OFS = 8'h04; // dram_control_b
    localparam logic [7:0] ASTATE_OFS = 8'h08; // access_state_control
    localparam logic [7:0] WAIT_H_OFS = 8'h0C; // wait_count_high
    localparam logic [7:0] WAIT_L_OFS = 8'h10; // wait_count_low
    localparam logic [7:0] AWIDTH_OFS = 8'h14; // area_width_control
    localparam logic [7:0] STATUS_OFS = 8'h18; // sequencer status
    // dram_control_a fields
    localparam int BURST_BIT = 0;     // burst_enable
    localparam int RAS_HOLD_BIT = 1;  // ras_hold_mode
    localparam int MODE_16M_BIT = 2;  // 16-Mbyte address mode
    // dram_control_b fields
    localparam int COLSEL_LO_BIT = 0; // column_bits_select_lo
    localparam int COLSEL_HI_BIT = 1; // column_bits_select_hi
    localparam int CAS_SEL_BIT = 2;   // cas_pin_select
    localparam int TWO_PRE_BIT = 3;   // two_precharge_select
    localparam int RCW_WAIT_BIT = 4;  // row_to_column_wait
    // reset values
    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [7:0] CTRL_B_RST = 8'h00;
    localparam logic [7:0] ASTATE_RST = 8'hFF;
    localparam logic [7:0] WAIT_RST = 8'hFF;
    localparam logic [7:0] AWIDTH_RST = 8'hFF;
    // access request from the bus controller
    typedef struct packed {
        logic valid;      // request pending
        logic refresh;    // cas-before-ras refresh request
        logic release_bus; // external bus release request
        logic other;      // access to a non-dram external space
        logic write;      // write access
        logic [2:0] area; // area number
        logic [23:0] addr; // byte address
    } dacc_req_t;
    // dram pin group
    typedef struct packed {
        logic ras_n;     // row strobe
        logic upper_column_strobe_n;    // upper_column_strobe
        logic lower_column_strobe_n;    // lower_column_strobe
        logic col_phase; // column address is on the bus
        logic refresh_n; // refresh cycle marker
    } dacc_dram_t;
endpackage : dacc_pkg

// ---- hw/dacc_seq.sv ----
// module: dram access cycle sequencer with wishbone configuration slave
`timescale 1ns/1ps
//
// Contract
// - full access: precharge, row, two column states
// - two_precharge_select adds second precharge state
// - access_state_control clear: no column waits
// - row_to_column_wait adds one row wait
// - access_state_control set: zero to three waits
// - refresh length ignores wait settings
// - external wait pin ignored for dram
// - 16-bit areas drive upper and lower strobes
// - cas_pin_select picks port pins or write strobes
// - 8-bit areas assert only upper strobe
// - all 8-bit, select 0: free pin five
// - idle state before non-dram after dram, only with cas_pin_select set
// - burst_enable allows fast-page column-only access
// - same-row burst access: two column states
// - burst column cycles take same waits
// - row compare range from width and mode
// - ras hold keeps row strobe during others
// - held row strobe dropped in four cases
// - hold mode off: release on other space
module dacc_seq (
    input wire logic ref_clk,
    input wire logic arst_n,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // bus controller side
    input wire dacc_pkg::dacc_req_t req_i,
    output logic req_done_o,
    input wire logic ext_wait_n, // external wait pin, unused for dram
    // pins
    output dacc_pkg::dacc_dram_t dram_o,
    output logic pin_four_n,
    output logic pin_five_n,
    output logic pin_five_gpio,
    output logic hwr_cas_n,
    output logic lwr_cas_n,
    output logic hwr_cas_en,
    output logic idle_o
);
    // ==========================================================
    // registers
    typedef enum {ST_IDLE, ST_PRE1, ST_PRE2, ST_ROW, ST_RWAIT, ST_COL1, ST_CWAIT, ST_COL2,
                  ST_RF1, ST_RF2, ST_RF3, ST_GAP} dacc_state_t;
    dacc_state_t st_r, st_nxt;
    logic [7:0] ctrl_a_r, ctrl_a_nxt, ctrl_b_r, ctrl_b_nxt, astate_r, astate_nxt;
    logic [7:0] wait_h_r, wait_h_nxt, wait_l_r, wait_l_nxt, awidth_r, awidth_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] rdat_r, rdat_nxt;
    logic ras_r, ras_nxt;             // row strobe held active
    logic [23:0] row_r, row_nxt;      // latched row address
    logic [1:0] wcnt_r, wcnt_nxt;     // column wait counter
    logic upper_column_strobe_r, upper_column_strobe_nxt, lower_column_strobe_r, lower_column_strobe_nxt, done_r, done_nxt, last_dram_r, last_dram_nxt;
    logic wait_sync1_r, wait_sync2_r; // wait pin is synchronised but never used for dram
    // ==========================================================
    // decode helpers
    // wait count for an area: two bits, high register holds areas 4..7
    function automatic logic [1:0] area_wait(input logic [2:0] a, input logic [7:0] wh, input logic [7:0] wl);
        logic [7:0] w;
        w = a[2] ? wh : wl;
        area_wait = w[{a[1:0], 1'b1} -: 2];
    endfunction : area_wait
    // row compare mask: top bit down to 9/10/11, one lower for 8-bit
    function automatic logic [23:0] row_mask(input logic [1:0] cs, input logic w8, input logic m16);
        logic [4:0] lo;
        logic [23:0] m;
        lo = 5'd9 + {3'd0, cs} - {4'd0, w8};
        m = 24'h000000;
        for (int i = 0; i < 24; i++) begin
            if (i >= lo && (m16 || i < 20)) begin
                m[i] = 1'b1;
            end
        end
        row_mask = m;
    endfunction : row_mask

    logic burst_on, hold_on, cas_sel, is8, same_row, waits_on;
    logic [1:0] colsel;
    assign burst_on = ctrl_a_r[dacc_pkg::BURST_BIT];
    assign hold_on = burst_on && ctrl_a_r[dacc_pkg::RAS_HOLD_BIT];
    assign cas_sel = ctrl_b_r[dacc_pkg::CAS_SEL_BIT];
    assign colsel = {ctrl_b_r[dacc_pkg::COLSEL_HI_BIT], ctrl_b_r[dacc_pkg::COLSEL_LO_BIT]};
    assign is8 = awidth_r[req_i.area];
    assign waits_on = astate_r[req_i.area];
    // illegal column code 11 never matches, so it always forces full access
    assign same_row = (colsel != 2'b11) &&
        (((req_i.addr ^ row_r) & row_mask(colsel, is8, ctrl_a_r[dacc_pkg::MODE_16M_BIT])) == 24'h000000);

    // ==========================================================
    // wishbone slave: one-cycle ack, unmapped reads zero, writes dropped
    always_comb begin
        ctrl_a_nxt = ctrl_a_r;
        ctrl_b_nxt = ctrl_b_r;
        astate_nxt = astate_r;
        wait_h_nxt = wait_h_r;
        wait_l_nxt = wait_l_r;
        awidth_nxt = awidth_r;
        ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
        rdat_nxt = rdat_r;
        if (ack_nxt) begin
            rdat_nxt = 32'h00000000;
            case (wb_adr_i)
                dacc_pkg::CTRL_A_OFS: rdat_nxt = {24'h000000, ctrl_a_r};
                dacc_pkg::CTRL_B_OFS: rdat_nxt = {24'h000000, ctrl_b_r};
                dacc_pkg::ASTATE_OFS: rdat_nxt = {24'h000000, astate_r};
                dacc_pkg::WAIT_H_OFS: rdat_nxt = {24'h000000, wait_h_r};
                dacc_pkg::WAIT_L_OFS: rdat_nxt = {24'h000000, wait_l_r};
                dacc_pkg::AWIDTH_OFS: rdat_nxt = {24'h000000, awidth_r};
                dacc_pkg::STATUS_OFS: rdat_nxt = {28'h0000000, wcnt_r, ras_r, st_r != ST_IDLE};
                default: rdat_nxt = 32'h00000000;
            endcase
            if (wb_we_i && wb_sel_i[0]) begin
                case (wb_adr_i)
                    dacc_pkg::CTRL_A_OFS: ctrl_a_nxt = wb_dat_i[7:0];
                    dacc_pkg::CTRL_B_OFS: ctrl_b_nxt = wb_dat_i[7:0];
                    dacc_pkg::ASTATE_OFS: astate_nxt = wb_dat_i[7:0];
                    dacc_pkg::WAIT_H_OFS: wait_h_nxt = wb_dat_i[7:0];
                    dacc_pkg::WAIT_L_OFS: wait_l_nxt = wb_dat_i[7:0];
                    dacc_pkg::AWIDTH_OFS: awidth_nxt = wb_dat_i[7:0];
                    default: ;
                endcase
            end
        end
    end

    // ==========================================================
    // access sequencer
    always_comb begin
        st_nxt = st_r;
        ras_nxt = ras_r;
        row_nxt = row_r;
        wcnt_nxt = wcnt_r;
        upper_column_strobe_nxt = 1'b0;
        lower_column_strobe_nxt = 1'b0;
        done_nxt = 1'b0;
        last_dram_nxt = last_dram_r;
        case (st_r)
            ST_IDLE: begin
                // dropping burst, or dropping hold after a non-dram access, releases a held row
                if (!hold_on && !(burst_on && last_dram_r)) begin
                    ras_nxt = 1'b0;
                end
                if (req_i.valid && !done_r) begin
                    if (req_i.refresh || req_i.release_bus) begin
                        ras_nxt = 1'b0; // row dropped before refresh or release
                        last_dram_nxt = 1'b0;
                        if (req_i.refresh) begin
                            st_nxt = ST_RF1;
                        end else begin
                            done_nxt = 1'b1;
                        end
                    end else if (req_i.other) begin
                        // without hold the row goes high on other space
                        if (!hold_on) begin
                            ras_nxt = 1'b0;
                        end
                        if (last_dram_r && cas_sel) begin
                            st_nxt = ST_GAP; // idle state when write strobes are shared
                        end else begin
                            done_nxt = 1'b1;
                        end
                        last_dram_nxt = 1'b0;
                    end else if (burst_on && ras_r && same_row) begin
                        st_nxt = ST_COL1; // column-only burst access
                        last_dram_nxt = 1'b1;
                    end else begin
                        ras_nxt = 1'b0; // different row: full access
                        row_nxt = req_i.addr;
                        st_nxt = ST_PRE1;
                        last_dram_nxt = 1'b1;
                    end
                end
            end
            ST_PRE1: st_nxt = ctrl_b_r[dacc_pkg::TWO_PRE_BIT] ? ST_PRE2 : ST_ROW;
            ST_PRE2: st_nxt = ST_ROW;
            ST_ROW: begin
                ras_nxt = 1'b1;
                st_nxt = ctrl_b_r[dacc_pkg::RCW_WAIT_BIT] ? ST_RWAIT : ST_COL1;
            end
            ST_RWAIT: st_nxt = ST_COL1;
            ST_COL1: begin
                // waits only when enabled for the area; pin ignored
                wcnt_nxt = area_wait(req_i.area, wait_h_r, wait_l_r);
                st_nxt = (waits_on && wcnt_nxt != 2'd0) ? ST_CWAIT : ST_COL2;
                upper_column_strobe_nxt = 1'b1;
                lower_column_strobe_nxt = !is8;
            end
            ST_CWAIT: begin
                wcnt_nxt = wcnt_r - 2'd1;
                st_nxt = (wcnt_r == 2'd1) ? ST_COL2 : ST_CWAIT;
                upper_column_strobe_nxt = 1'b1;
                lower_column_strobe_nxt = !is8;
            end
            ST_COL2: begin
                done_nxt = 1'b1;
                st_nxt = ST_IDLE;
            end
            // refresh length set only by two_precharge_select, no wait registers consulted
            ST_RF1: st_nxt = ctrl_b_r[dacc_pkg::TWO_PRE_BIT] ? ST_RF2 : ST_RF3;
            ST_RF2: st_nxt = ST_RF3;
            ST_RF3: begin
                done_nxt = 1'b1;
                st_nxt = ST_IDLE;
            end
            ST_GAP: begin
                done_nxt = 1'b1;
                st_nxt = ST_IDLE;
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    // ==========================================================
    // state registers
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_a_r <= dacc_pkg::CTRL_A_RST;
            ctrl_b_r <= dacc_pkg::CTRL_B_RST;
            astate_r <= dacc_pkg::ASTATE_RST;
            wait_h_r <= dacc_pkg::WAIT_RST;
            wait_l_r <= dacc_pkg::WAIT_RST;
            awidth_r <= dacc_pkg::AWIDTH_RST;
            ack_r <= 1'b0;
            rdat_r <= 32'h00000000;
            st_r <= ST_IDLE;
            ras_r <= 1'b0;
            row_r <= 24'h000000;
            wcnt_r <= 2'd0;
            upper_column_strobe_r <= 1'b0;
            lower_column_strobe_r <= 1'b0;
            done_r <= 1'b0;
            last_dram_r <= 1'b0;
            wait_sync1_r <= 1'b1;
            wait_sync2_r <= 1'b1;
        end else begin
            ctrl_a_r <= ctrl_a_nxt;
            ctrl_b_r <= ctrl_b_nxt;
            astate_r <= astate_nxt;
            wait_h_r <= wait_h_nxt;
            wait_l_r <= wait_l_nxt;
            awidth_r <= awidth_nxt;
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
            st_r <= st_nxt;
            ras_r <= ras_nxt;
            row_r <= row_nxt;
            wcnt_r <= wcnt_nxt;
            upper_column_strobe_r <= upper_column_strobe_nxt;
            lower_column_strobe_r <= lower_column_strobe_nxt;
            done_r <= done_nxt;
            last_dram_r <= last_dram_nxt;
            wait_sync1_r <= ext_wait_n;
            wait_sync2_r <= wait_sync1_r;
        end
    end

    // ==========================================================
    // outputs and pin routing
    logic all8;
    assign all8 = &awidth_r;
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;
    assign req_done_o = done_r;
    assign idle_o = (st_r == ST_GAP);
    assign dram_o.ras_n = !ras_r;
    assign dram_o.upper_column_strobe_n = !upper_column_strobe_r;
    assign dram_o.lower_column_strobe_n = !lower_column_strobe_r;
    assign dram_o.col_phase = upper_column_strobe_r;
    assign dram_o.refresh_n = !(st_r == ST_RF1 || st_r == ST_RF2 || st_r == ST_RF3);
    // strobes steered to port pins or write strobe pins
    assign pin_four_n = cas_sel ? 1'b1 : !upper_column_strobe_r;
    assign pin_five_n = cas_sel ? 1'b1 : !lower_column_strobe_r;
    assign hwr_cas_n = cas_sel ? !upper_column_strobe_r : 1'b1;
    assign lwr_cas_n = cas_sel ? !lower_column_strobe_r : 1'b1;
    assign hwr_cas_en = cas_sel;
    assign pin_five_gpio = all8 && !cas_sel;
endmodule : dacc_seq

// ---- testbench/dacc_seq_checker.sv ----
// concurrent port checks for the dram access sequencer
`timescale 1ns/1ps
module dacc_seq_checker (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire dacc_pkg::dacc_req_t req_i,
    input wire logic req_done_o,
    input wire dacc_pkg::dacc_dram_t dram_o,
    input wire logic pin_four_n,
    input wire logic pin_five_n,
    input wire logic pin_five_gpio,
    input wire logic hwr_cas_n,
    input wire logic lwr_cas_n,
    input wire logic hwr_cas_en,
    input wire logic idle_o
);
    // ==========================================
    // one clock domain, so one default clocking
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    chk_pins_port: assert property (!hwr_cas_en |-> pin_four_n == dram_o.upper_column_strobe_n && pin_five_n == dram_o.lower_column_strobe_n
        && hwr_cas_n && lwr_cas_n) else $error("strobe routed wrong with port pins selected");
    chk_pins_wr: assert property (hwr_cas_en |-> hwr_cas_n == dram_o.upper_column_strobe_n && lwr_cas_n == dram_o.lower_column_strobe_n
        && pin_four_n && pin_five_n) else $error("strobe routed wrong with write pins selected");
    chk_gpio_lower_column_strobe: assert property (pin_five_gpio |-> dram_o.lower_column_strobe_n && !hwr_cas_en)
        else $error("lower strobe active while its pin is free");
    chk_access_len: assert property ($rose(req_i.valid) && !req_i.refresh && !req_i.other
        && !req_i.release_bus |-> !req_done_o [*2] ##[1:9] req_done_o) else $error("access length out of range");
    chk_refresh_len: assert property ($rose(req_i.valid) && req_i.refresh |-> ##[2:4] req_done_o)
        else $error("refresh length out of range");
    chk_other_fast: assert property ($rose(req_i.valid) && req_i.other |-> ##[1:3] req_done_o)
        else $error("other space access too long");
    chk_gap_done: assert property (idle_o |=> req_done_o)
        else $error("idle gap not followed by completion");
    chk_cas_row: assert property (!dram_o.upper_column_strobe_n && dram_o.refresh_n |-> !dram_o.ras_n)
        else $error("column strobe without open row");
endmodule : dacc_seq_checker
bind dacc_seq dacc_seq_checker u_chk (.ref_clk(ref_clk), .arst_n(arst_n), .req_i(req_i), .req_done_o(req_done_o),
    .dram_o(dram_o), .pin_four_n(pin_four_n), .pin_five_n(pin_five_n), .pin_five_gpio(pin_five_gpio),
    .hwr_cas_n(hwr_cas_n), .lwr_cas_n(lwr_cas_n), .hwr_cas_en(hwr_cas_en), .idle_o(idle_o));

// ---- testbench/dacc_dram_model.sv ----
// model of the page-mode dram: counts column strobe cycles per data half
`timescale 1ns/1ps
module dacc_dram_model (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic ras_n,
    input wire logic upper_column_strobe_n,
    input wire logic lower_column_strobe_n,
    output int upper_column_strobe_cnt,
    output int lower_column_strobe_cnt
);
    // ==========================================
    // a half latches data only while its row is open; refresh strobes are not counted
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            upper_column_strobe_cnt <= 0;
            lower_column_strobe_cnt <= 0;
        end else begin
            upper_column_strobe_cnt <= upper_column_strobe_cnt + int'(!upper_column_strobe_n && !ras_n);
            lower_column_strobe_cnt <= lower_column_strobe_cnt + int'(!lower_column_strobe_n && !ras_n);
        end
    end
endmodule : dacc_dram_model

// ---- testbench/dacc_seq_tb.sv ----
// testbench: register access and dram cycle sequences of the sequencer
`timescale 1ns/1ps
module dacc_seq_tb;
    logic ref_clk = 1'h0, arst_n = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, ext_wait_n = 1'h1;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, rd;
    logic ack, done, p4, p5, gp, hw, lw, hen, idle;
    dacc_pkg::dacc_req_t req = '0; // request level, held until done
    dacc_pkg::dacc_dram_t dram;
    int fail_count = 0, n_tests = 0, uc, lc, du, dl, c, w;
    logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
    logic [7:0] rst [7] = '{dacc_pkg::CTRL_A_RST, dacc_pkg::CTRL_B_RST, dacc_pkg::ASTATE_RST,
        dacc_pkg::WAIT_RST, dacc_pkg::WAIT_RST, dacc_pkg::AWIDTH_RST, 8'h00};
    dacc_seq DUT (.ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .req_i(req),
        .req_done_o(done), .ext_wait_n(ext_wait_n), .dram_o(dram), .pin_four_n(p4), .pin_five_n(p5),
        .pin_five_gpio(gp), .hwr_cas_n(hw), .lwr_cas_n(lw), .hwr_cas_en(hen), .idle_o(idle));
    dacc_dram_model u_dram (.ref_clk(ref_clk), .arst_n(arst_n), .ras_n(dram.ras_n), .upper_column_strobe_n(dram.upper_column_strobe_n),
        .lower_column_strobe_n(dram.lower_column_strobe_n), .upper_column_strobe_cnt(uc), .lower_column_strobe_cnt(lc));
    // ==========================================
    // 100 MHz clock
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
        end
    endtask : check
    // one classic wishbone cycle; request held until the rising edge that samples ack high
    task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= wr;
        adr <= a;
        wdat <= d;
        for (k = 0; k < 50; k++) begin
            @(posedge ref_clk);
            if (ack === 1'h1) break;
        end
        check("wb ack", k < 50, 1'h1);
        if (k == 50) summarize();
        rd = rdat; // read data taken at the edge that sees ack
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask : wb
    // one request; k = {refresh, release, other, write}; exp counts the states plus the done cycle
    task automatic acc(input logic [3:0] k, input logic [23:0] a, input int exp);
        int n, u0, l0;
        u0 = uc;
        l0 = lc;
        @(posedge ref_clk);
        req <= '{1'h1, k[3], k[2], k[1], k[0], 3'h2, a};
        for (n = 0; n < 40; n++) begin
            @(posedge ref_clk);
            if (done === 1'h1) break;
        end
        check("cycles", n, exp);
        if (n == 40) summarize();
        req <= '0; // dropped on the edge that samples done high
        du = uc - u0;
        dl = lc - l0;
    endtask : acc
    // ==========================================
    // main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'h1;
        wb(1'h1, 8'h1C, 32'hFF); // unmapped write is dropped
        foreach (ofs[i]) begin
            wb(1'h0, ofs[i], 32'h0);
            check("reset value", rd, {24'h0, rst[i]});
        end
        check("gpio free", gp, 1'h1);
        acc(4'h1, 24'h0, 8);
        check("lower 8bit", dl, 0);
        wb(1'h1, 8'h14, 32'hFB); // area two is 16-bit
        check("gpio taken", gp, 1'h0);
        wb(1'h1, 8'h08, 32'hFB);
        acc(4'h0, 24'h0, 5);
        check("both halves", dl == du && du > 0, 1'h1);
        wb(1'h1, 8'h08, 32'hFF);
        ext_wait_n <= 1'h0; // wait pin held active on dram cycles
        for (c = 0; c < 4; c++) begin
            wb(1'h1, 8'h10, 32'hCF | (c << 4));
            acc(4'h0, 24'h0, 5 + c);
        end
        ext_wait_n <= 1'h1;
        for (c = 0; c < 4; c++) begin
            wb(1'h1, 8'h04, (c & 1) << 3 | (c >> 1) << 4);
            acc(4'h0, 24'h0, 8 + (c & 1) + (c >> 1));
            acc(4'h8, 24'h0, 3 + (c & 1));
        end
        wb(1'h1, 8'h04, 32'h04);
        check("write pins", hen, 1'h1);
        acc(4'h1, 24'h0, 8);
        acc(4'h2, 24'h0, 2);
        wb(1'h1, 8'h04, 32'h00);
        acc(4'h0, 24'h0, 8);
        acc(4'h2, 24'h0, 1);
        wb(1'h1, 8'h00, 32'h01); // burst on, hold off
        for (w = 0; w < 2; w++) begin
            wb(1'h1, 8'h14, w ? 32'hFF : 32'hFB);
            for (c = 0; c < 3; c++) begin
                wb(1'h1, 8'h04, c);
                wb(1'h1, 8'h10, 32'hCF | (c << 4));
                acc(4'h4, 24'h0, 1);
                acc(4'h0, 24'h0, 5 + c);
                acc(4'h0, 24'h1 << (8 + c - w), 3 + c);
                acc(4'h0, 24'h1 << (9 + c - w), 5 + c);
            end
        end
        wb(1'h1, 8'h08, 32'hFB); // no column waits from here
        wb(1'h1, 8'h04, 32'h03); // illegal column code: same row still gets full access
        acc(4'h0, 24'h400, 5);
        wb(1'h1, 8'h04, 32'h00);
        acc(4'h2, 24'h0, 1);
        acc(4'h0, 24'h400, 5); // same row, but row strobe was released
        wb(1'h1, 8'h00, 32'h03); // hold mode; write pins are not shared
        acc(4'h0, 24'h0, 5);
        acc(4'h2, 24'h0, 1);
        check("row held", dram.ras_n, 1'h0);
        acc(4'h0, 24'h0, 3);
        acc(4'h8, 24'h0, 3); // refresh only by the built-in cycle
        acc(4'h0, 24'h0, 5);
        wb(1'h1, 8'h00, 32'h00);
        @(posedge ref_clk); // row strobe falls one edge after the write lands
        check("row closed", dram.ras_n, 1'h1);
        wb(1'h1, 8'h00, 32'h03);
        acc(4'h0, 24'h0, 5);
        acc(4'h4, 24'h0, 1);
        acc(4'h0, 24'h0, 5);
        wb(1'h1, 8'h00, 32'h01); // hold off before any standby
        summarize();
    end
endmodule : dacc_seq_tb
